// ---- logic/rmpcg_port_gate.v ----
// One glitch-free port clock gate built from a latch-free enable register.
// Assumes the port logic uses clk with the clock enable this cell produces.
module rmpcg_port_gate (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Gate request and result
  input wire gate_on,
  output reg port_clk_en_reg
);

  // The enable changes only on a clock edge, so the gated port never sees a runt cycle.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      port_clk_en_reg <= 1'b0;
    else
      port_clk_en_reg <= gate_on;
  end

endmodule // rmpcg_port_gate

// ---- logic/rmpcg_top.v ----
// Run-mode port clock gating registers with an Avalon-MM slave and fault detection.
// Assumes the system bus decoder raises port_access with the addressed port index.
`include "rmpcg_regs.vh"

module rmpcg_top #(
  parameter NUM_PORTS = `RMPCG_NUM_PORTS
) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Avalon-MM slave
  input wire [11:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  output reg [1:0] response,
  // Power mode from the power controller
  input wire [1:0] power_mode,
  // Port access monitor on the system bus
  input wire port_access,
  input wire [2:0] port_index,
  output reg port_bus_fault,
  // Clock enables to the ports
  output wire [NUM_PORTS-1:0] port_clk_en,
  // Interrupt
  output reg irq
);

  reg [NUM_PORTS-1:0] run_mode_port_clock_gates_reg;
  reg [NUM_PORTS-1:0] sleep_mode_port_clock_gates_reg;
  reg [NUM_PORTS-1:0] deep_sleep_port_clock_gates_reg;
  reg [31:0] run_mode_clock_config_reg;
  reg [1:0] irq_status_reg;
  reg [1:0] irq_mask_reg;
  reg [2:0] fault_port_reg;
  reg [NUM_PORTS-1:0] active_gates_reg;
  reg [NUM_PORTS-1:0] active_gates_next;
  reg [NUM_PORTS-1:0] prev_gates_reg;
  reg [1:0] irq_status_next;
  reg [31:0] rdata_next;
  reg access_pending_reg;
  wire auto_gating_select;
  wire bus_req;
  wire wr_ok;
  wire fault_now;
  wire gate_change;
  wire wr_run_gates;
  wire wr_sleep_gates;
  wire wr_deep_gates;
  wire wr_clk_config;
  wire wr_irq_mask;
  wire clr_irq_status;

  // Merge write data under byte enables.
  function [31:0] rmpcg_merge;
    input [31:0] old_val;
    input [31:0] new_val;
    input [3:0] be;
    integer i;
    begin
      rmpcg_merge = old_val;
      for (i = 0; i < 4; i = i + 1)
        if (be[i])
          rmpcg_merge[i*8 +: 8] = new_val[i*8 +: 8];
    end
  endfunction

  // True when the bus address hits a mapped register.
  function rmpcg_mapped;
    input [11:0] a;
    begin
      case (a)
        `RMPCG_OFS_RUN_GATES: rmpcg_mapped = 1'b1;
        `RMPCG_OFS_SLEEP_GATES: rmpcg_mapped = 1'b1;
        `RMPCG_OFS_DEEP_GATES: rmpcg_mapped = 1'b1;
        `RMPCG_OFS_CLK_CONFIG: rmpcg_mapped = 1'b1;
        `RMPCG_OFS_MODE: rmpcg_mapped = 1'b1;
        `RMPCG_OFS_IRQ_STATUS: rmpcg_mapped = 1'b1;
        `RMPCG_OFS_IRQ_MASK: rmpcg_mapped = 1'b1;
        `RMPCG_OFS_FAULT_INFO: rmpcg_mapped = 1'b1;
        default: rmpcg_mapped = 1'b0;
      endcase
    end
  endfunction

  // True for an accepted write whose low byte lane lands on the given register.
  function rmpcg_lane0_hit;
    input wr;
    input [11:0] a;
    input [11:0] ofs;
    input [3:0] be;
    begin
      rmpcg_lane0_hit = wr && (a == ofs) && be[0];
    end
  endfunction

  assign auto_gating_select = run_mode_clock_config_reg[`RMPCG_AUTO_GATING_BIT];
  // Every access takes one wait cycle so read data always come from a register.
  assign bus_req = (read || write) && !access_pending_reg;
  assign wr_ok = write && access_pending_reg;
  assign fault_now = port_access && !active_gates_reg[port_index];
  assign gate_change = (prev_gates_reg != active_gates_reg);
  assign wr_run_gates = rmpcg_lane0_hit(wr_ok, address, `RMPCG_OFS_RUN_GATES, byteenable);
  assign wr_sleep_gates = rmpcg_lane0_hit(wr_ok, address, `RMPCG_OFS_SLEEP_GATES, byteenable);
  assign wr_deep_gates = rmpcg_lane0_hit(wr_ok, address, `RMPCG_OFS_DEEP_GATES, byteenable);
  assign wr_irq_mask = rmpcg_lane0_hit(wr_ok, address, `RMPCG_OFS_IRQ_MASK, byteenable);
  assign clr_irq_status = rmpcg_lane0_hit(wr_ok, address, `RMPCG_OFS_IRQ_STATUS, byteenable);
  assign wr_clk_config = wr_ok && (address == `RMPCG_OFS_CLK_CONFIG);

  // Select which gate set drives the ports.
  always @*
  begin
    active_gates_next = run_mode_port_clock_gates_reg;
    if (auto_gating_select)
    begin
      case (power_mode)
        `RMPCG_MODE_SLEEP: active_gates_next = sleep_mode_port_clock_gates_reg;
        `RMPCG_MODE_DEEP: active_gates_next = deep_sleep_port_clock_gates_reg;
        default: active_gates_next = run_mode_port_clock_gates_reg;
      endcase
    end
  end

  // Read mux; unmapped and reserved bits read as zero.
  always @*
  begin
    rdata_next = 32'h00000000;
    case (address)
      `RMPCG_OFS_RUN_GATES: rdata_next[NUM_PORTS-1:0] = run_mode_port_clock_gates_reg;
      `RMPCG_OFS_SLEEP_GATES: rdata_next[NUM_PORTS-1:0] = sleep_mode_port_clock_gates_reg;
      `RMPCG_OFS_DEEP_GATES: rdata_next[NUM_PORTS-1:0] = deep_sleep_port_clock_gates_reg;
      `RMPCG_OFS_CLK_CONFIG: rdata_next = run_mode_clock_config_reg;
      `RMPCG_OFS_MODE: rdata_next[NUM_PORTS-1:0] = active_gates_reg;
      `RMPCG_OFS_IRQ_STATUS: rdata_next[1:0] = irq_status_reg;
      `RMPCG_OFS_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
      `RMPCG_OFS_FAULT_INFO: rdata_next[2:0] = fault_port_reg;
      default: rdata_next = 32'h00000000;
    endcase
  end

  // Sticky status: a new event wins over a write-one clear in the same cycle.
  always @*
  begin
    irq_status_next = irq_status_reg;
    if (clr_irq_status)
      irq_status_next = irq_status_reg & ~writedata[1:0];
    if (fault_now)
      irq_status_next[`RMPCG_IRQ_FAULT_BIT] = 1'b1;
    if (gate_change)
      irq_status_next[`RMPCG_IRQ_GATE_CHANGE_BIT] = 1'b1;
  end

  // Bus handshake.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      access_pending_reg <= 1'b0;
      waitrequest <= 1'b1;
    end
    else
    begin
      access_pending_reg <= bus_req;
      waitrequest <= !bus_req;
    end
  end

  // Read data and response are taken once per request and then held for the master.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      readdata <= 32'h00000000;
      response <= `RMPCG_RESP_OKAY;
    end
    else if (bus_req)
    begin
      readdata <= read ? rdata_next : 32'h00000000;
      response <= rmpcg_mapped(address) ? `RMPCG_RESP_OKAY : `RMPCG_RESP_DECODE_ERR;
    end
  end

  // Gate registers keep only the low byte; the reserved upper bits are dropped.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      run_mode_port_clock_gates_reg <= `RMPCG_GATES_RESET;
    else if (wr_run_gates)
      run_mode_port_clock_gates_reg <= writedata[NUM_PORTS-1:0];
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sleep_mode_port_clock_gates_reg <= `RMPCG_GATES_RESET;
    else if (wr_sleep_gates)
      sleep_mode_port_clock_gates_reg <= writedata[NUM_PORTS-1:0];
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      deep_sleep_port_clock_gates_reg <= `RMPCG_GATES_RESET;
    else if (wr_deep_gates)
      deep_sleep_port_clock_gates_reg <= writedata[NUM_PORTS-1:0];
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      run_mode_clock_config_reg <= `RMPCG_CLK_CONFIG_RESET;
    else if (wr_clk_config)
      run_mode_clock_config_reg <= rmpcg_merge(run_mode_clock_config_reg, writedata,
        byteenable);
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq_mask_reg <= `RMPCG_IRQ_RESET;
    else if (wr_irq_mask)
      irq_mask_reg <= writedata[1:0];
  end

  // Gate tracking.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      active_gates_reg <= `RMPCG_GATES_RESET;
      prev_gates_reg <= `RMPCG_GATES_RESET;
    end
    else
    begin
      active_gates_reg <= active_gates_next;
      prev_gates_reg <= active_gates_reg;
    end
  end

  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq_status_reg <= `RMPCG_IRQ_RESET;
    else
      irq_status_reg <= irq_status_next;
  end

  // A fault is judged on the gates in force, which may be a low-power set.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      port_bus_fault <= 1'b0;
      fault_port_reg <= 3'h0;
    end
    else
    begin
      port_bus_fault <= fault_now;
      if (fault_now)
        fault_port_reg <= port_index;
    end
  end

  // The interrupt follows the next status value so it rises with the event itself.
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      irq <= 1'b0;
    else
      irq <= |(irq_status_next & irq_mask_reg);
  end

  // One gate cell per port, bit n driving port n.
  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g = g + 1)
    begin : gate_cells
      rmpcg_port_gate u_gate (
        .clk(clk),
        .nrst(nrst),
        .gate_on(active_gates_reg[g]),
        .port_clk_en_reg(port_clk_en[g])
      );
    end
  endgenerate

endmodule // rmpcg_top

// ---- pkg/rmpcg_regs.vh ----
// Register offsets, field positions and reset values of the port clock gating block.
// Assumes byte addressing on a 32-bit Avalon-MM slave port.
`ifndef RMPCG_REGS_VH
`define RMPCG_REGS_VH
`define RMPCG_OFS_RUN_GATES 12'h108
`define RMPCG_OFS_SLEEP_GATES 12'h118
`define RMPCG_OFS_DEEP_GATES 12'h128
`define RMPCG_OFS_CLK_CONFIG 12'h060
`define RMPCG_OFS_MODE 12'h140
`define RMPCG_OFS_IRQ_STATUS 12'h150
`define RMPCG_OFS_IRQ_MASK 12'h154
`define RMPCG_OFS_FAULT_INFO 12'h158
`define RMPCG_GATES_RESET 8'h00
`define RMPCG_CLK_CONFIG_RESET 32'h00000000
`define RMPCG_IRQ_RESET 2'h0
`define RMPCG_RESP_OKAY 2'h0
`define RMPCG_RESP_DECODE_ERR 2'h3
`define RMPCG_AUTO_GATING_BIT 27
`define RMPCG_IRQ_FAULT_BIT 0
`define RMPCG_IRQ_GATE_CHANGE_BIT 1
`define RMPCG_MODE_RUN 2'h0
`define RMPCG_MODE_SLEEP 2'h1
`define RMPCG_MODE_DEEP 2'h2
`define RMPCG_NUM_PORTS 8
`endif

// ---- sim/rmpcg_chk.sv ----
// Checker for the port clock gating block, bound to rmpcg_top.
// Assumes the bus master holds requests until waitrequest is low.
module rmpcg_chk #(parameter NUM_PORTS = 8) (
  // Clock and reset
  input wire clk,
  input wire nrst,
  // Register bus
  input wire [11:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire [1:0] response,
  // Ports
  input wire [1:0] power_mode,
  input wire port_access,
  input wire [2:0] port_index,
  input wire port_bus_fault,
  input wire [NUM_PORTS-1:0] port_clk_en,
  // Interrupt
  input wire irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  property p_ans; $rose(read | write) |=> !waitrequest; endproperty
  a_ans: assert property (p_ans) else $error("no answer");
  property p_one; !waitrequest |=> waitrequest; endproperty
  a_one: assert property (p_one) else $error("answer too long");
  property p_rsv; read && !waitrequest && address == 12'h108 |-> readdata[31:8] == 24'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_unm; read && !waitrequest && address == 12'h004 |-> response == 2'h3;
  endproperty
  a_unm: assert property (p_unm) else $error("unmapped answered ok");
  property p_rst; $rose(nrst) |-> port_clk_en == '0 && !port_bus_fault && !irq; endproperty
  a_rst: assert property (p_rst) else $error("gates not clear");
  // The enables lag the active gates by one cycle, so they show what the fault logic saw.
  property p_flt; port_access |=> port_bus_fault == !port_clk_en[$past(port_index)];
  endproperty
  a_flt: assert property (p_flt) else $error("fault wrong");
  property p_nof; !port_access |=> !port_bus_fault; endproperty
  a_nof: assert property (p_nof) else $error("spurious fault");
  property p_gate; write && !waitrequest && address == 12'h108 && byteenable[0] &&
    power_mode == 2'h0 ##1 (power_mode == 2'h0) [*2] |=> port_clk_en == $past(writedata[7:0], 3);
  endproperty
  a_gate: assert property (p_gate) else $error("gate lost");
  property p_irqm; write && !waitrequest && address == 12'h154 && byteenable[0] &&
    writedata[1:0] == 2'h0 |=> ##1 !irq;
  endproperty
  a_irqm: assert property (p_irqm) else $error("masked interrupt raised");
endmodule // rmpcg_chk

bind rmpcg_top rmpcg_chk #(.NUM_PORTS(NUM_PORTS)) u_chk (.*);

// ---- sim/rmpcg_tb.sv ----
// Self-checking bench for the port clock gating block.
// Assumes rmpcg_top answers each bus request after one cycle.
module run_mode_port_clock_gating_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, nrst, read, write, port_access, port_bus_fault, waitrequest, irq;
  logic [11:0] address;
  logic [31:0] writedata, readdata, rd, r;
  logic [3:0] byteenable;
  logic [1:0] response, rsp, power_mode;
  logic [2:0] port_index;
  logic [7:0] port_clk_en;
  int miscompares, n_tests, mdl_run, mdl_mask;
  int exp_q[$];
  rmpcg_top u_rmpcg_top (.*);
  initial
  begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e)
    begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input bit w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    read <= !w;
    write <= w;
    do
    begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    if (n >= 50) miscompares++;
    rd = readdata;
    rsp = response;
    read <= 0;
    write <= 0;
  endtask
  task automatic acc(input int p, input logic e);
    @(posedge clk);
    port_access <= 1;
    port_index <= 3'(p);
    @(posedge clk);
    port_access <= 0;
    @(posedge clk);
    chk(port_bus_fault, e);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    #50us;
    miscompares++;
    results();
  end
  initial
  begin
    {nrst, read, write, port_access, port_index, power_mode} = '0;
    {address, writedata} = '0;
    byteenable = 4'hF;
    void'($urandom(74182));
    repeat (5) @(posedge clk);
    nrst <= 1;
    bus(0, 12'h108, 0);
    chk(rd, 0);
    chk(port_clk_en, 0);
    $display("reset test done");
    for (int i = 0; i < 8; i++)
    begin
      r = $urandom;
      mdl_run = 1 << i;
      exp_q.push_back(mdl_run);
      bus(1, 12'h108, {r[31:8], 8'(mdl_run)});
      bus(0, 12'h108, 0);
      chk(rd, exp_q.pop_front());
      repeat (3) @(posedge clk);
      chk(port_clk_en, mdl_run);
      acc(i, !mdl_run[i]);
      acc((i + 1) % 8, !mdl_run[(i + 1) % 8]);
    end
    bus(0, 12'h108, 0);
    bus(1, 12'h108, rd | 32'h1);
    mdl_run = mdl_run | 1;
    bus(0, 12'h108, 0);
    chk(rd, mdl_run);
    $display("port test done");
    bus(0, 12'h004, 0);
    chk(rsp, 3);
    chk(rd, 0);
    // Stale status is cleared first, so the interrupt can only come from the new fault.
    bus(1, 12'h150, 32'h3);
    bus(1, 12'h154, 1);
    mdl_mask = 1;
    repeat (2) @(posedge clk);
    chk(irq, 0);
    acc(1, !mdl_run[1]);
    repeat (2) @(posedge clk);
    chk(irq, mdl_mask[0]);
    bus(1, 12'h150, 1);
    @(posedge clk);
    chk(irq, 0);
    bus(1, 12'h154, 0);
    mdl_mask = 0;
    acc(1, !mdl_run[1]);
    repeat (2) @(posedge clk);
    chk(irq, mdl_mask[0]);
    bus(0, 12'h150, 0);
    chk(rd[0], 1);
    $display("irq test done");
    bus(1, 12'h118, 32'h0F);
    bus(1, 12'h060, 32'h0800_0000);
    power_mode <= 1;
    repeat (4) @(posedge clk);
    chk(port_clk_en, 8'h0F);
    bus(1, 12'h060, 0);
    repeat (4) @(posedge clk);
    chk(port_clk_en, mdl_run);
    power_mode <= 0;
    $display("mode test done");
    nrst <= 0;
    repeat (2) @(posedge clk);
    nrst <= 1;
    bus(0, 12'h108, 0);
    chk(rd, 0);
    chk(port_clk_en, 0);
    chk(irq, 0);
    $display("second reset test done");
    results();
  end
endmodule // run_mode_port_clock_gating_tb_top
